// >>> include/byte_alu_regs.svh
// Constants for the byte ALU datapath: direction selectors, flag positions, widths.
// Assumes inclusion by bare name from the design files.
`ifndef BYTE_ALU_REGS_SVH
`define BYTE_ALU_REGS_SVH
`define ALU_WIDTH 8
`define ALU_FADDR_W 7
`define ALU_NIB_LO_HI 3
`define ALU_NIB_HI_LO 4
`define ALU_ZERO_BYTE 8'h00
`define ALU_DIR_RESET 8'hFF
`define ALU_DIR_SEL_A 7'h05
`define ALU_DIR_SEL_B 7'h06
`define ALU_DIR_SEL_C 7'h07
`define ALU_FLAG_C 0
`define ALU_FLAG_HALF 1
`define ALU_FLAG_Z 2
`define ALU_DEST_ACC 1'b0
`define ALU_DEST_FILE 1'b1
`endif

// >>> include/byte_alu_pkg.sv
// Types shared by the byte ALU datapath.
// Assumes nothing beyond a SystemVerilog compiler.
package byte_alu_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SUB_BORROW = 3'h1,
        OP_SWAP = 3'h2,
        OP_XOR_LIT = 3'h3,
        OP_XOR_FILE = 3'h4,
        OP_DIR_LOAD = 3'h5
    } alu_op_type;
endpackage : byte_alu_pkg

// >>> verilog/byte_subtractor.sv
// Subtractor with borrow-in, giving result, carry (no borrow) and digit carry.
// Assumes operands are stable within the cycle; purely combinational.
`timescale 1ns/1ps
`include "byte_alu_regs.svh"
module byte_subtractor #(
    parameter int WIDTH = `ALU_WIDTH
) (
    input wire logic [WIDTH-1:0] minuend, // File operand
    input wire logic [WIDTH-1:0] subtrahend, // Accumulator operand
    input wire logic carry_in, // Carry; low means borrow
    output logic [WIDTH-1:0] diff, // Result
    output logic carry_out, // High when no borrow
    output logic half_carry_out // High when no low-nibble borrow
);
    logic [WIDTH:0] full_sum;
    logic [`ALU_NIB_HI_LO:0] nib_sum;
    // Two's complement: a + ~b + c equals a - b - not c.
    assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, carry_in};
    assign nib_sum = {1'b0, minuend[`ALU_NIB_LO_HI:0]} + {1'b0, ~subtrahend[`ALU_NIB_LO_HI:0]}
        + {{`ALU_NIB_HI_LO{1'b0}}, carry_in};
    assign diff = full_sum[WIDTH-1:0];
    assign carry_out = full_sum[WIDTH];
    assign half_carry_out = nib_sum[`ALU_NIB_HI_LO];
endmodule : byte_subtractor

// >>> verilog/byte_alu_subtract_swap_xor.sv
// Execution datapath for five byte instructions: subtract with borrow,
// nibble swap, xor literal, xor file and direction load.
// Assumes the decoder presents one operation per instruction-clock enable.
// Functional notes
// - Subtract with borrow computes file minus accumulator minus inverted carry.
// - Destination bit 0 writes accumulator; 1 writes the file register.
// - Subtract with borrow updates carry, half carry and zero.
// - Nibble swap exchanges file nibbles; destination selectable; flags unchanged.
// - Xor literal combines accumulator and literal into accumulator; zero only.
// - Direction load copies accumulator into port A, B or C direction register.
// - Xor file combines accumulator and file; destination selectable; zero only.
// - Carry clears when subtrahend plus borrow (inverted carry) exceeds minuend; half carry likewise on nibbles.
`timescale 1ns/1ps
`include "byte_alu_regs.svh"
module byte_alu_subtract_swap_xor
    import byte_alu_pkg::*;
#(
    parameter int WIDTH = `ALU_WIDTH
) (
    input wire logic CLK, // Core clock
    input wire logic RST, // Asynchronous reset, active high
    input wire logic EXEC_EN, // Instruction-clock enable pulse
    input wire alu_op_type OP, // Operation to execute
    input wire logic DEST_SEL, // Destination select bit
    input wire logic [`ALU_FADDR_W-1:0] FILE_ADDR, // File address or direction selector
    input wire logic [WIDTH-1:0] FILE_DATA, // Addressed file register value
    input wire logic [WIDTH-1:0] LITERAL, // Immediate operand
    output logic [WIDTH-1:0] ACC, // Accumulator
    output logic CARRY, // Carry flag
    output logic HALF_CARRY, // Half carry flag
    output logic ZERO, // Zero flag
    output logic FILE_WE, // File write strobe
    output logic [`ALU_FADDR_W-1:0] FILE_WADDR, // File write address
    output logic [WIDTH-1:0] FILE_WDATA, // File write data
    output logic [WIDTH-1:0] PORT_A_DIR, // Port A direction register
    output logic [WIDTH-1:0] PORT_B_DIR, // Port B direction register
    output logic [WIDTH-1:0] PORT_C_DIR // Port C direction register
);
    logic [WIDTH-1:0] acc_q;
    logic carry_q;
    logic half_carry_q;
    logic zero_q;
    logic file_we_q;
    logic [`ALU_FADDR_W-1:0] file_waddr_q;
    logic [WIDTH-1:0] file_wdata_q;
    logic [WIDTH-1:0] port_a_direction_reg_q;
    logic [WIDTH-1:0] port_b_direction_reg_q;
    logic [WIDTH-1:0] port_c_direction_reg_q;

    wire logic [WIDTH-1:0] sub_diff;
    wire logic sub_carry;
    wire logic sub_half;
    byte_subtractor #(.WIDTH(WIDTH)) u_sub (
        .minuend(FILE_DATA),
        .subtrahend(acc_q),
        .carry_in(carry_q),
        .diff(sub_diff),
        .carry_out(sub_carry),
        .half_carry_out(sub_half)
    );

    wire logic subtract_with_borrow_op = EXEC_EN && (OP == OP_SUB_BORROW);
    wire logic nibble_swap_op = EXEC_EN && (OP == OP_SWAP);
    wire logic xor_literal_op = EXEC_EN && (OP == OP_XOR_LIT);
    wire logic xor_file_op = EXEC_EN && (OP == OP_XOR_FILE);
    wire logic direction_load_op = EXEC_EN && (OP == OP_DIR_LOAD);

    wire logic [WIDTH-1:0] swap_res = {FILE_DATA[`ALU_NIB_LO_HI:0],
        FILE_DATA[WIDTH-1:`ALU_NIB_HI_LO]};
    wire logic [WIDTH-1:0] xlit_res = acc_q ^ LITERAL;
    wire logic [WIDTH-1:0] xfile_res = acc_q ^ FILE_DATA;

    wire logic routed_op = subtract_with_borrow_op || nibble_swap_op || xor_file_op;
    wire logic [WIDTH-1:0] routed_res = subtract_with_borrow_op ? sub_diff :
        nibble_swap_op ? swap_res : xfile_res;
    wire logic to_acc = (routed_op && DEST_SEL == `ALU_DEST_ACC) || xor_literal_op;
    wire logic to_file = routed_op && DEST_SEL == `ALU_DEST_FILE;
    wire logic [WIDTH-1:0] acc_d = xor_literal_op ? xlit_res : routed_res;
    wire logic [WIDTH-1:0] zero_src = xor_literal_op ? xlit_res : routed_res;
    wire logic zero_upd = subtract_with_borrow_op || xor_file_op || xor_literal_op;
    wire logic zero_d = (zero_src == `ALU_ZERO_BYTE);

    wire logic dir_a = direction_load_op && FILE_ADDR == `ALU_DIR_SEL_A;
    wire logic dir_b = direction_load_op && FILE_ADDR == `ALU_DIR_SEL_B;
    wire logic dir_c = direction_load_op && FILE_ADDR == `ALU_DIR_SEL_C;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            acc_q <= `ALU_ZERO_BYTE;
            carry_q <= 1'b0;
            half_carry_q <= 1'b0;
            zero_q <= 1'b0;
        end
        else
        begin
            if (to_acc)
            begin
                acc_q <= acc_d;
            end
            if (subtract_with_borrow_op)
            begin
                carry_q <= sub_carry;
                half_carry_q <= sub_half;
            end
            if (zero_upd)
            begin
                zero_q <= zero_d;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            file_we_q <= 1'b0;
            file_waddr_q <= '0;
            file_wdata_q <= `ALU_ZERO_BYTE;
        end
        else
        begin
            file_we_q <= to_file;
            if (to_file)
            begin
                file_waddr_q <= FILE_ADDR;
                file_wdata_q <= routed_res;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            port_a_direction_reg_q <= `ALU_DIR_RESET;
            port_b_direction_reg_q <= `ALU_DIR_RESET;
            port_c_direction_reg_q <= `ALU_DIR_RESET;
        end
        else
        begin
            if (dir_a)
            begin
                port_a_direction_reg_q <= acc_q;
            end
            if (dir_b)
            begin
                port_b_direction_reg_q <= acc_q;
            end
            if (dir_c)
            begin
                port_c_direction_reg_q <= acc_q;
            end
        end
    end

    assign ACC = acc_q;
    assign CARRY = carry_q;
    assign HALF_CARRY = half_carry_q;
    assign ZERO = zero_q;
    assign FILE_WE = file_we_q;
    assign FILE_WADDR = file_waddr_q;
    assign FILE_WDATA = file_wdata_q;
    assign PORT_A_DIR = port_a_direction_reg_q;
    assign PORT_B_DIR = port_b_direction_reg_q;
    assign PORT_C_DIR = port_c_direction_reg_q;

    chk_sub_result: assert property (@(posedge CLK) disable iff (RST)
        subtract_with_borrow_op && !DEST_SEL |=> ACC == $past(FILE_DATA) - $past(acc_q)
        - {7'h00, !$past(carry_q)})
        else $error("Subtract result wrong");
    chk_file_route: assert property (@(posedge CLK) disable iff (RST)
        routed_op && DEST_SEL |=> FILE_WE && ACC == $past(acc_q) && FILE_WDATA == $past(routed_res))
        else $error("File destination routing wrong");
    chk_sub_carry: assert property (@(posedge CLK) disable iff (RST)
        subtract_with_borrow_op |=> CARRY == ({1'b0, $past(FILE_DATA)} >=
        {1'b0, $past(acc_q)} + {8'h00, !$past(carry_q)}))
        else $error("Carry after subtract wrong");
    chk_swap_flags: assert property (@(posedge CLK) disable iff (RST)
        nibble_swap_op |=> $stable(CARRY) && $stable(ZERO) && $stable(HALF_CARRY))
        else $error("Swap changed a flag");
    chk_swap_value: assert property (@(posedge CLK) disable iff (RST)
        nibble_swap_op && !DEST_SEL |=> ACC == {$past(FILE_DATA[3:0]), $past(FILE_DATA[7:4])})
        else $error("Swap result wrong");
    chk_xor_lit: assert property (@(posedge CLK) disable iff (RST)
        xor_literal_op |=> ACC == ($past(acc_q) ^ $past(LITERAL)) && $stable(CARRY) && !FILE_WE)
        else $error("Xor literal wrong");
    chk_dir_load: assert property (@(posedge CLK) disable iff (RST)
        dir_b |=> PORT_B_DIR == $past(acc_q) && $stable(PORT_A_DIR) && $stable(ZERO))
        else $error("Direction load wrong");
    chk_xor_file: assert property (@(posedge CLK) disable iff (RST)
        xor_file_op |=> ZERO == (($past(acc_q) ^ $past(FILE_DATA)) == 8'h00) && $stable(CARRY))
        else $error("Xor file wrong");
    chk_zero_flag: assert property (@(posedge CLK) disable iff (RST)
        zero_upd ##1 1'b1 |-> ZERO == ($past(zero_src) == 8'h00))
        else $error("Zero flag wrong");
    chk_sub_half: assert property (@(posedge CLK) disable iff (RST)
        subtract_with_borrow_op |=> HALF_CARRY ==
        ({1'b0, $past(FILE_DATA[`ALU_NIB_LO_HI:0])} >=
        {1'b0, $past(acc_q[`ALU_NIB_LO_HI:0])} + {4'h0, !$past(carry_q)}))
        else $error("Half carry after subtract wrong");
    chk_sub_zero: assert property (@(posedge CLK) disable iff (RST)
        subtract_with_borrow_op |=> ZERO == (($past(FILE_DATA) - $past(acc_q)
        - {7'h00, !$past(carry_q)}) == `ALU_ZERO_BYTE))
        else $error("Zero after subtract wrong");
    chk_acc_route: assert property (@(posedge CLK) disable iff (RST)
        routed_op && !DEST_SEL |=> ACC == $past(routed_res) && !FILE_WE)
        else $error("Accumulator destination routing wrong");
    chk_swap_file: assert property (@(posedge CLK) disable iff (RST)
        nibble_swap_op && DEST_SEL |=> FILE_WDATA == {$past(FILE_DATA[`ALU_NIB_LO_HI:0]),
        $past(FILE_DATA[WIDTH-1:`ALU_NIB_HI_LO])} && $stable(ACC))
        else $error("Swap to file wrong");
    chk_xor_file_acc: assert property (@(posedge CLK) disable iff (RST)
        xor_file_op && !DEST_SEL |=> ACC == ($past(acc_q) ^ $past(FILE_DATA)) && $stable(HALF_CARRY))
        else $error("Xor file to accumulator wrong");
    chk_dir_a: assert property (@(posedge CLK) disable iff (RST)
        dir_a |=> PORT_A_DIR == $past(acc_q) && $stable(CARRY))
        else $error("Port A direction load wrong");
    chk_dir_c: assert property (@(posedge CLK) disable iff (RST)
        dir_c |=> PORT_C_DIR == $past(acc_q) && $stable(HALF_CARRY))
        else $error("Port C direction load wrong");
    chk_dir_ignored: assert property (@(posedge CLK) disable iff (RST)
        direction_load_op && !dir_a && !dir_b && !dir_c |=>
        $stable(PORT_A_DIR) && $stable(PORT_B_DIR) && $stable(PORT_C_DIR))
        else $error("Direction load with bad selector changed a port");
    // An idle cycle must leave the accumulator, carry and zero flags alone, since the core may stall between ops; the write strobe clears.
    chk_idle_hold: assert property (@(posedge CLK) disable iff (RST)
        !EXEC_EN |=> $stable(ACC) && $stable(CARRY) && $stable(ZERO) && !FILE_WE)
        else $error("Idle cycle changed state");
endmodule : byte_alu_subtract_swap_xor

// >>> tb/file_reg_model.sv
// Register file model standing in for the core behind the byte ALU.
// Assumes writes arrive as a one-cycle strobe sampled on the rising edge.
`timescale 1ns/1ps
module file_reg_model (
    input wire logic clk, // Core clock
    input wire logic [6:0] raddr, // Read address
    input wire logic we, // Write strobe
    input wire logic [6:0] waddr, // Write address
    input wire logic [7:0] wdata, // Write data
    output logic [7:0] rdata // Read data
);
    logic [7:0] mem [128];
    initial
    begin
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37) ^ 8'h5a;
    end
    assign rdata = mem[raddr];
    always @(posedge clk)
    begin
        if (we) mem[waddr] <= wdata;
    end
endmodule : file_reg_model

// >>> tb/byte_alu_subtract_swap_xor_test.sv
// Self-checking bench for the byte ALU datapath and a register file model.
// Assumes outputs settle within 1 ns after an enabled edge.
`timescale 1ns/1ps
module byte_alu_subtract_swap_xor_test import byte_alu_pkg::*;;
    logic CLK = 0, RST = 1, EXEC_EN = 0, DEST_SEL = 0;
    alu_op_type OP = OP_NONE;
    logic [6:0] FILE_ADDR = 0;
    logic [7:0] LITERAL = 0;
    wire logic [7:0] FILE_DATA, ACC, FILE_WDATA, PORT_A_DIR, PORT_B_DIR, PORT_C_DIR;
    wire logic [6:0] FILE_WADDR;
    wire logic CARRY, HALF_CARRY, ZERO, FILE_WE;
    logic [7:0] acc_e = 0, r, dir_e [3] = '{8'hff, 8'hff, 8'hff};
    logic c_e = 0, h_e = 0, z_e = 0, we_e = 0;
    int fail_count = 0, n_checks = 0, cycles = 0;
    byte_alu_subtract_swap_xor byte_alu_subtract_swap_xor_inst (.CLK, .RST, .EXEC_EN, .OP,
        .DEST_SEL, .FILE_ADDR, .FILE_DATA, .LITERAL, .ACC, .CARRY, .HALF_CARRY, .ZERO,
        .FILE_WE, .FILE_WADDR, .FILE_WDATA, .PORT_A_DIR, .PORT_B_DIR, .PORT_C_DIR);
    file_reg_model file_reg_model_inst (.clk(CLK), .raddr(FILE_ADDR), .we(FILE_WE),
        .waddr(FILE_WADDR), .wdata(FILE_WDATA), .rdata(FILE_DATA));
    initial forever #5 CLK = ~CLK;
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count++;
            complete_run();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [7:0] exp_result(alu_op_type op, logic [7:0] f, w, k, logic c);
        return op == OP_SUB_BORROW ? f - w - 8'(!c) : op == OP_SWAP ? {f[3:0], f[7:4]}
            : op == OP_XOR_LIT ? w ^ k : f ^ w;
    endfunction : exp_result
    task automatic run_op(alu_op_type op, logic en, d, logic [6:0] a, logic [7:0] k);
        logic [8:0] full;
        logic [4:0] low;
        EXEC_EN = en;
        OP = op;
        DEST_SEL = d;
        FILE_ADDR = a;
        LITERAL = k;
        #1;
        full = {1'b0, FILE_DATA} - {1'b0, acc_e} - 9'(!c_e);
        low = {1'b0, FILE_DATA[3:0]} - {1'b0, acc_e[3:0]} - 5'(!c_e);
        r = exp_result(op, FILE_DATA, acc_e, k, c_e);
        we_e = en && d && op inside {OP_SUB_BORROW, OP_SWAP, OP_XOR_FILE};
        if (en && op == OP_SUB_BORROW)
        begin
            c_e = !full[8];
            h_e = !low[4];
        end
        if (en && op inside {OP_SUB_BORROW, OP_XOR_LIT, OP_XOR_FILE})
            z_e = (r == 8'h00);
        if (en && op == OP_DIR_LOAD && a inside {[5:7]})
            dir_e[a - 5] = acc_e;
        if (en && (op == OP_XOR_LIT || !d && op inside {OP_SUB_BORROW, OP_SWAP, OP_XOR_FILE}))
            acc_e = r;
        @(posedge CLK);
        #1;
        EXEC_EN = 0;
        check(ACC, acc_e);
        check({5'h0, CARRY, HALF_CARRY, ZERO}, {5'h0, c_e, h_e, z_e});
        check({7'h0, FILE_WE}, {7'h0, we_e});
        if (we_e) check(FILE_WDATA, r);
        if (we_e) check({1'b0, FILE_WADDR}, {1'b0, a});
        check(PORT_A_DIR, dir_e[0]);
        check(PORT_B_DIR, dir_e[1]);
        check(PORT_C_DIR, dir_e[2]);
        @(posedge CLK);
        #1;
    endtask : run_op
    initial
    begin
        void'($urandom(32'hda29));
        repeat (2) @(posedge CLK);
        #1 RST = 0;
        check(ACC, 8'h00);
        check(PORT_A_DIR & PORT_B_DIR & PORT_C_DIR, 8'hff);
        check({5'h0, CARRY, HALF_CARRY, ZERO}, 8'h00);
        check({7'h0, FILE_WE}, 8'h00);
        $display("reset test done");
        for (int a = 4; a < 8; a++)
        begin
            run_op(OP_XOR_LIT, 1, 1, 7'h00, 8'(a * 17));
            run_op(OP_DIR_LOAD, 1, 0, 7'(a), 8'h00);
        end
        run_op(OP_XOR_LIT, 1, 1, 7'h00, acc_e);
        run_op(OP_XOR_LIT, 1, 0, 7'h00, 8'hff);
        $display("corner test done");
        repeat (400)
            run_op(alu_op_type'($urandom_range(5)), 1'($urandom_range(7) != 0),
                1'($urandom_range(1)),
                $urandom_range(1) ? 7'($urandom_range(7, 4)) : 7'($urandom), 8'($urandom));
        $display("random test done");
        complete_run();
    end
endmodule : byte_alu_subtract_swap_xor_test
